// *** nfh_host.sv ***
`timescale 1ns/10ps
// Functional notes
// - Ready/busy only pulls low; host side supplies the pull-up.
// - x8 address is four cycles: column A0-A11 low first, then row A12-A27.
// - Upper four bits of the second x8 address cycle are driven low.
// - x16 address: column A0-A10, row A11-A26; bits 15-8 and spare bits low.
// - During data output both latches low, select low, write strobe high.
// - Commands, addresses and data share one 8 or 16 bit bus.
// - Page read is 00h, four addresses, 30h; 00h already held after power-on.
// - Host never issues command codes outside the defined set.
module nfh_host (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          resetn,
    // Mode and write guard control
    input  wire logic                          x16_mode,
    input  wire logic                          write_allow,
    // Request port
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire nfh_pkg::nfh_kind_t            req_kind,
    input  wire logic [nfh_pkg::BUS_W-1:0]     req_data,
    input  wire logic [nfh_pkg::ADDR_W-1:0]    req_addr,
    output logic                               cmd_reject,
    // Read data port
    output logic                               rd_valid,
    input  wire logic                          rd_ready,
    output logic [nfh_pkg::BUS_W-1:0]          rd_data,
    // Device status
    output logic                               dev_busy,
    // Device pins
    output logic                               ce_n,
    output logic                               cle,
    output logic                               ale,
    output logic                               we_n,
    output logic                               read_strobe_n,
    output logic                               wp_n,
    output logic [nfh_pkg::BUS_W-1:0]          io_out,
    output logic                               io_oe,
    input  wire logic [nfh_pkg::BUS_W-1:0]     io_in,
    input  wire logic                          ready_busy_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    nfh_pkg::nfh_state_t              state_ff, nxt_state;
    logic [nfh_pkg::CNT_W-1:0]        cnt_ff, nxt_cnt;
    logic [1:0]                       aix_ff, nxt_aix;
    logic [nfh_pkg::ADDR_W-1:0]       addr_ff, nxt_addr;
    logic                             rdy_ff, nxt_rdy;
    logic                             rej_ff, nxt_rej;
    logic                             busy_ff, nxt_busy;
    logic                             ce_n_ff, nxt_ce_n;
    logic                             cle_ff, nxt_cle;
    logic                             ale_ff, nxt_ale;
    logic                             we_n_ff, nxt_we_n;
    logic                             read_strobe_n_ff, nxt_read_strobe_n;
    logic                             wp_n_ff, nxt_wp_n;
    logic [nfh_pkg::BUS_W-1:0]        out_ff, nxt_out;
    logic                             oe_ff, nxt_oe;
    logic                             push;
    logic [nfh_pkg::BUS_W-1:0]        push_data;
    logic [1:0]                       cnt_q_ff, nxt_cnt_q;
    logic [nfh_pkg::BUS_W-1:0]        head_ff, nxt_head;
    logic [nfh_pkg::BUS_W-1:0]        tail_ff, nxt_tail;
    logic                             val_ff, nxt_val;
    logic                             pop;

    // Address cycle packing per bus width
    function automatic logic [nfh_pkg::BUS_W-1:0] pack_addr(input logic [nfh_pkg::ADDR_W-1:0] a,
                                                           input logic [1:0] ix, input logic w16);
        logic [7:0] b;
        b = 8'h00;
        if (!w16) begin
            case (ix)
                2'h0:    b = a[7:0];
                2'h1:    b = {4'h0, a[11:8]};
                2'h2:    b = a[19:12];
                default: b = a[27:20];
            endcase
        end else begin
            case (ix)
                2'h0:    b = a[7:0];
                2'h1:    b = {5'h00, a[10:8]};
                2'h2:    b = a[18:11];
                default: b = a[26:19];
            endcase
        end
        return {8'h00, b};
    endfunction : pack_addr

    ////////////////////////////////////////////////////////////////////////////
    // Bus sequencer

    assign push      = (state_ff == nfh_pkg::ST_RLOW) && (cnt_ff == '0);
    assign push_data = x16_mode ? io_in : {8'h00, io_in[7:0]};

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_aix   = aix_ff;
        nxt_addr  = addr_ff;
        nxt_rej   = 1'b0;
        nxt_ce_n  = ce_n_ff;
        nxt_cle   = cle_ff;
        nxt_ale   = ale_ff;
        nxt_we_n  = we_n_ff;
        nxt_read_strobe_n = read_strobe_n_ff;
        nxt_out   = out_ff;
        nxt_oe    = oe_ff;
        nxt_wp_n  = write_allow;
        nxt_busy  = ~ready_busy_n;
        case (state_ff)
            nfh_pkg::ST_IDLE: begin
                if (req_valid && rdy_ff) begin
                    nxt_cnt = nfh_pkg::WE_LOW_LD;
                    case (req_kind)
                        nfh_pkg::K_CMD: begin
                            if (nfh_pkg::cmd_legal(req_data[7:0])) begin
                                nxt_state = nfh_pkg::ST_WLOW;
                                nxt_cle   = 1'b1;
                                nxt_out   = {8'h00, req_data[7:0]};
                            end else begin
                                nxt_rej   = 1'b1;
                            end
                        end
                        nfh_pkg::K_ADDR: begin
                            nxt_state = nfh_pkg::ST_WLOW;
                            nxt_ale   = 1'b1;
                            nxt_addr  = req_addr;
                            nxt_aix   = 2'h0;
                            nxt_out   = pack_addr(req_addr, 2'h0, x16_mode);
                        end
                        nfh_pkg::K_WDATA: begin
                            nxt_state = nfh_pkg::ST_WLOW;
                            nxt_out   = x16_mode ? req_data : {8'h00, req_data[7:0]};
                        end
                        default: begin
                            nxt_state = nfh_pkg::ST_RLOW;
                            nxt_cnt   = nfh_pkg::RD_ACC_LD;
                        end
                    endcase
                    if (nxt_state != nfh_pkg::ST_IDLE) begin
                        nxt_ce_n = 1'b0;
                        nxt_oe   = (nxt_state == nfh_pkg::ST_WLOW);
                        nxt_we_n = (nxt_state != nfh_pkg::ST_WLOW);
                        nxt_read_strobe_n = (nxt_state != nfh_pkg::ST_RLOW);
                    end
                end
            end
            nfh_pkg::ST_WLOW: begin
                if (cnt_ff == '0) begin
                    nxt_state = nfh_pkg::ST_WHIGH;
                    nxt_we_n  = 1'b1;
                    nxt_cnt   = nfh_pkg::WE_HIGH_LD;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            nfh_pkg::ST_WHIGH: begin
                if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - 1'b1;
                end else if (ale_ff && aix_ff != nfh_pkg::LAST_ADDR_IX) begin
                    nxt_state = nfh_pkg::ST_WLOW;
                    nxt_aix   = aix_ff + 1'b1;
                    nxt_out   = pack_addr(addr_ff, aix_ff + 1'b1, x16_mode);
                    nxt_we_n  = 1'b0;
                    nxt_cnt   = nfh_pkg::WE_LOW_LD;
                end else begin
                    nxt_state = nfh_pkg::ST_IDLE;
                    nxt_cle   = 1'b0;
                    nxt_ale   = 1'b0;
                    nxt_oe    = 1'b0;
                    nxt_ce_n  = 1'b1;
                end
            end
            nfh_pkg::ST_RLOW: begin
                if (cnt_ff == '0) begin
                    nxt_state = nfh_pkg::ST_RHIGH;
                    nxt_read_strobe_n = 1'b1;
                    nxt_cnt   = nfh_pkg::RD_HIGH_LD;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            nfh_pkg::ST_RHIGH: begin
                if (cnt_ff == '0) begin
                    nxt_state = nfh_pkg::ST_IDLE;
                    nxt_ce_n  = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            default: begin
                nxt_state = nfh_pkg::ST_IDLE;
                nxt_ce_n  = 1'b1;
                nxt_cle   = 1'b0;
                nxt_ale   = 1'b0;
                nxt_we_n  = 1'b1;
                nxt_read_strobe_n = 1'b1;
                nxt_oe    = 1'b0;
            end
        endcase
        nxt_rdy = (nxt_state == nfh_pkg::ST_IDLE) && (nxt_cnt_q != 2'h2);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_ff <= nfh_pkg::ST_IDLE;
            cnt_ff   <= '0;
            aix_ff   <= 2'h0;
            addr_ff  <= '0;
            rdy_ff   <= 1'b0;
            rej_ff   <= 1'b0;
            busy_ff  <= 1'b0;
            ce_n_ff  <= 1'b1;
            cle_ff   <= 1'b0;
            ale_ff   <= 1'b0;
            we_n_ff  <= 1'b1;
            read_strobe_n_ff <= 1'b1;
            wp_n_ff  <= 1'b0;
            out_ff   <= '0;
            oe_ff    <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            aix_ff   <= nxt_aix;
            addr_ff  <= nxt_addr;
            rdy_ff   <= nxt_rdy;
            rej_ff   <= nxt_rej;
            busy_ff  <= nxt_busy;
            ce_n_ff  <= nxt_ce_n;
            cle_ff   <= nxt_cle;
            ale_ff   <= nxt_ale;
            we_n_ff  <= nxt_we_n;
            read_strobe_n_ff <= nxt_read_strobe_n;
            wp_n_ff  <= nxt_wp_n;
            out_ff   <= nxt_out;
            oe_ff    <= nxt_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry read buffer

    assign pop = val_ff && rd_ready;

    always_comb begin
        nxt_head  = head_ff;
        nxt_tail  = tail_ff;
        nxt_cnt_q = cnt_q_ff;
        case ({push, pop})
            2'b10: begin
                if (cnt_q_ff == 2'h0) nxt_head = push_data;
                else                  nxt_tail = push_data;
                nxt_cnt_q = cnt_q_ff + 2'h1;
            end
            2'b01: begin
                nxt_head  = tail_ff;
                nxt_cnt_q = cnt_q_ff - 2'h1;
            end
            2'b11: begin
                if (cnt_q_ff == 2'h1) nxt_head = push_data;
                else begin
                    nxt_head = tail_ff;
                    nxt_tail = push_data;
                end
            end
            default: begin
                nxt_cnt_q = cnt_q_ff;
            end
        endcase
        nxt_val = (nxt_cnt_q != 2'h0);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            head_ff  <= '0;
            tail_ff  <= '0;
            cnt_q_ff <= 2'h0;
            val_ff   <= 1'b0;
        end else begin
            head_ff  <= nxt_head;
            tail_ff  <= nxt_tail;
            cnt_q_ff <= nxt_cnt_q;
            val_ff   <= nxt_val;
        end
    end

    assign req_ready  = rdy_ff;
    assign cmd_reject = rej_ff;
    assign rd_valid   = val_ff;
    assign rd_data    = head_ff;
    assign dev_busy   = busy_ff;
    assign ce_n       = ce_n_ff;
    assign cle        = cle_ff;
    assign ale        = ale_ff;
    assign we_n       = we_n_ff;
    assign read_strobe_n = read_strobe_n_ff;
    assign wp_n       = wp_n_ff;
    assign io_out     = out_ff;
    assign io_oe      = oe_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence we_pulse_s;
        $fell(we_n_ff) ##1 $rose(we_n_ff);
    endsequence

    sequence addr_walk_s;
        (aix_ff == 2'h0) ##2 (aix_ff == 2'h1) ##2 (aix_ff == 2'h2) ##2 (aix_ff == 2'h3) ##2 !ale_ff;
    endsequence

    idle_deselect_a: assert property ((state_ff == nfh_pkg::ST_IDLE) |-> ce_n_ff)
        else $error("chip select low while idle");
    strobe_select_a: assert property ((!we_n_ff || !read_strobe_n_ff) |-> !ce_n_ff)
        else $error("strobe active without chip select");
    we_pulse_a: assert property ($fell(we_n_ff) |-> we_pulse_s)
        else $error("write strobe low width wrong");
    cle_stable_a: assert property ((cle_ff && !we_n_ff) |=> cle_ff && oe_ff)
        else $error("command latch dropped at strobe rise");
    ale_stable_a: assert property ((ale_ff && !we_n_ff) |=> ale_ff && oe_ff)
        else $error("address latch dropped at strobe rise");
    read_quiet_a: assert property (!read_strobe_n_ff |-> we_n_ff && !cle_ff && !ale_ff && !oe_ff)
        else $error("read strobe with bad control levels");
    addr_four_a: assert property ((ale_ff && $fell(we_n_ff) && aix_ff == 2'h0) |-> addr_walk_s)
        else $error("address phase not four cycles");
    x8_high_a: assert property ((ale_ff && !x16_mode && aix_ff == 2'h1 && !we_n_ff) |->
                                io_out[7:4] == 4'h0)
        else $error("second address cycle upper bits set");
    upper_low_a: assert property ((ale_ff && !we_n_ff) |-> io_out[15:8] == 8'h00)
        else $error("address upper byte not low");
    read_push_a: assert property ($rose(read_strobe_n_ff) && $past(cnt_q_ff) != 2'h2 |->
                                  $past(push))
        else $error("read strobe ended without capture");
    guard_follow_a: assert property ($past(resetn) |-> wp_n_ff == $past(write_allow))
        else $error("write guard does not follow control");
    bad_cmd_a: assert property ((req_valid && rdy_ff && req_kind == nfh_pkg::K_CMD &&
                                 !nfh_pkg::cmd_legal(req_data[7:0])) |=> rej_ff && ce_n_ff)
        else $error("undefined command reached the bus");

endmodule : nfh_host

// *** nfh_pkg.sv ***
package nfh_pkg;

    // Bus and address geometry
    localparam int          BUS_W        = 16;
    localparam int          ADDR_W       = 28;
    localparam int          CNT_W        = 3;
    localparam logic [1:0]  LAST_ADDR_IX = 2'h3;

    // Array organisation
    localparam int          BLOCKS       = 1024;
    localparam int          PAGES        = 64;
    localparam int          MAIN_BYTES   = 2048;
    localparam int          SPARE_BYTES  = 64;
    localparam int          PAGE_WORDS16 = 1056;

    // Command codes
    localparam logic [7:0]  OP_READ      = 8'h00;
    localparam logic [7:0]  OP_READ_GO   = 8'h30;
    localparam logic [7:0]  OP_CB_READ   = 8'h35;
    localparam logic [7:0]  OP_ID        = 8'h90;
    localparam logic [7:0]  OP_STATUS    = 8'h70;
    localparam logic [7:0]  OP_RESET     = 8'hff;
    localparam logic [7:0]  OP_PROG      = 8'h80;
    localparam logic [7:0]  OP_CB_PROG   = 8'h85;
    localparam logic [7:0]  OP_PROG_GO   = 8'h10;
    localparam logic [7:0]  OP_ERASE     = 8'h60;
    localparam logic [7:0]  OP_ERASE_GO  = 8'hd0;
    localparam logic [7:0]  OP_RND_OUT   = 8'h05;
    localparam logic [7:0]  OP_RND_GO    = 8'he0;
    localparam logic [7:0]  OP_PARAM     = 8'hec;

    // Timing
    localparam int          CLK_MHZ      = 20;
    localparam int          WE_LOW_NS    = 25;
    localparam int          WE_HIGH_NS   = 15;
    localparam int          READ_ACCESS_DELAY_NS = 20;
    localparam int          RD_HIGH_NS   = 10;

    function automatic int cyc_up(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    localparam logic [CNT_W-1:0] WE_LOW_LD  = CNT_W'(cyc_up(WE_LOW_NS) - 1);
    localparam logic [CNT_W-1:0] WE_HIGH_LD = CNT_W'(cyc_up(WE_HIGH_NS) - 1);
    localparam logic [CNT_W-1:0] RD_ACC_LD  = CNT_W'(cyc_up(READ_ACCESS_DELAY_NS) - 1);
    localparam logic [CNT_W-1:0] RD_HIGH_LD = CNT_W'(cyc_up(RD_HIGH_NS) - 1);

    typedef enum logic [1:0] {
        K_CMD   = 2'h0,
        K_ADDR  = 2'h1,
        K_WDATA = 2'h2,
        K_RDATA = 2'h3
    } nfh_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_WLOW  = 3'h1,
        ST_WHIGH = 3'h3,
        ST_RLOW  = 3'h2,
        ST_RHIGH = 3'h6
    } nfh_state_t;

    function automatic logic cmd_legal(input logic [7:0] c);
        case (c)
            OP_READ, OP_READ_GO, OP_CB_READ, OP_ID, OP_STATUS, OP_RESET, OP_PROG,
            OP_CB_PROG, OP_PROG_GO, OP_ERASE, OP_ERASE_GO, OP_RND_OUT, OP_RND_GO,
            OP_PARAM: return 1'b1;
            default:  return 1'b0;
        endcase
    endfunction : cmd_legal

endpackage : nfh_pkg

// *** nfh_dev_model.sv ***
`timescale 1ns/10ps
module nfh_dev_model #(
    parameter int BUSY_NS = 600
) (
    // Bus packing
    input  wire logic        x16_mode,
    // Control pins
    input  wire logic        ce_n,
    input  wire logic        cle,
    input  wire logic        ale,
    input  wire logic        we_n,
    input  wire logic        read_strobe_n,
    input  wire logic        wp_n,
    // Shared bus and status
    input  wire logic [15:0] io_out,
    output logic      [15:0] io_in,
    output logic             rb_low
);
    logic [7:0]  cmd_q = 8'h00;
    logic [15:0] ab [4];
    logic [15:0] data_reg [16];
    logic [15:0] mem [16];
    logic [15:0] rd_q = 16'h0000;
    logic [3:0]  col = 4'h0;
    int          acnt = 0;
    logic        prog = 1'b0;
    event        kick;

    initial begin
        rb_low = 1'b0;
        for (int i = 0; i < 16; i++) mem[i] = 16'h5a00 + 16'(i);
    end

    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            cmd_q = io_out[7:0];
            acnt = 0;
            if (cmd_q == 8'h80) data_reg = mem;
            if (cmd_q == 8'h30 || (cmd_q == 8'h10 && wp_n)) begin
                prog = (cmd_q == 8'h10);
                -> kick;
            end
        end else if (!ce_n && ale) begin
            if (acnt < 4) ab[acnt] = io_out;
            if (acnt == 0) col = io_out[3:0];
            acnt++;
        end else if (!ce_n && read_strobe_n) begin
            data_reg[col] = x16_mode ? io_out : {8'h00, io_out[7:0]};
            col++;
        end
    end

    // Array transfer while status is pulled low
    always @(kick) begin
        rb_low = 1'b1;
        #(BUSY_NS);
        if (prog) mem = data_reg;
        else data_reg = mem;
        rb_low = 1'b0;
    end

    always @(negedge read_strobe_n) begin
        if (!ce_n) begin
            rd_q <= #20 data_reg[col];
            col++;
        end
    end

    // Released bus shows the inverse, never the last word
    assign io_in = (!ce_n && !read_strobe_n) ? rd_q : ~rd_q;
endmodule : nfh_dev_model

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
    logic                       clock = 1'b0;
    logic                       resetn = 1'b0;
    logic                       x16_mode = 1'b0;
    logic                       write_allow = 1'b1;
    logic                       req_valid = 1'b0;
    nfh_pkg::nfh_kind_t         req_kind = nfh_pkg::K_CMD;
    logic [15:0]                req_data = 16'h0000;
    logic [27:0]                req_addr = 28'h0;
    logic                       rd_ready = 1'b0;
    logic                       req_ready, cmd_reject, rd_valid, dev_busy, rb_low, ready_busy_n;
    logic                       ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_oe;
    logic [15:0]                io_out, io_in, rd_data;
    int                         n_errors = 0;
    int                         compares = 0;
    logic [15:0]                exp_mem [16];
    logic [7:0]                 codes [14] = '{8'h00, 8'h30, 8'h35, 8'h90, 8'h70, 8'hff, 8'h80,
                                               8'h85, 8'h10, 8'h60, 8'hd0, 8'h05, 8'he0, 8'hec};

    assign ready_busy_n = rb_low ? 1'b0 : 1'b1;

    nfh_host i_dut (.clock(clock), .resetn(resetn), .x16_mode(x16_mode), .write_allow(write_allow),
        .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_data(req_data),
        .req_addr(req_addr), .cmd_reject(cmd_reject), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rd_data), .dev_busy(dev_busy), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
        .ready_busy_n(ready_busy_n));
    nfh_dev_model i_dev (.x16_mode(x16_mode), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out), .io_in(io_in), .rb_low(rb_low));

    initial begin
        forever #25 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : chk1

    task automatic send(input nfh_pkg::nfh_kind_t k, input logic [15:0] d, input logic [27:0] a);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        chk1(req_ready, 1'b1);
        req_kind = k;
        req_data = d;
        req_addr = a;
        req_valid = 1'b1;
        @(negedge clock);
        req_valid = 1'b0;
    endtask : send

    task automatic settle(output logic seen);
        int n;
        seen = 1'b0;
        for (n = 0; n < 6; n++) begin
            @(negedge clock);
            seen = seen | (dev_busy === 1'b1);
        end
        n = 0;
        while (dev_busy !== 1'b0 && n < 100) begin
            @(negedge clock);
            n++;
        end
        chk1(dev_busy, 1'b0);
    endtask : settle

    task automatic pop(input logic [15:0] e);
        int n;
        n = 0;
        rd_ready = 1'b1;
        while (rd_valid !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        chk(rd_data, e);
        @(negedge clock);
        rd_ready = 1'b0;
    endtask : pop

    task automatic results;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    function automatic logic [15:0] pack(input logic [27:0] a, input int i, input logic w);
        logic [7:0] b;
        case (i)
            0: b = a[7:0];
            1: b = w ? {5'h00, a[10:8]} : {4'h0, a[11:8]};
            2: b = w ? a[18:11] : a[19:12];
            default: b = w ? a[26:19] : a[27:20];
        endcase
        return {8'h00, b};
    endfunction : pack

    function automatic logic legal(input logic [7:0] c);
        foreach (codes[i]) if (codes[i] == c) return 1'b1;
        return 1'b0;
    endfunction : legal

    function automatic logic [15:0] rexp(input logic [3:0] c);
        return x16_mode ? exp_mem[c] : {8'h00, exp_mem[c][7:0]};
    endfunction : rexp

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(50 * 20000);
        n_errors++;
        results();
    end

    initial begin
        logic        s;
        logic [7:0]  u;
        logic [27:0] a;
        logic [3:0]  c;
        logic [15:0] d;
        void'($urandom(26));
        for (int i = 0; i < 16; i++) exp_mem[i] = 16'h5a00 + 16'(i);
        repeat (8) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        for (int m = 0; m < 2; m++) begin
            x16_mode = m[0];
            foreach (codes[i]) begin
                send(nfh_pkg::K_CMD, {8'h00, codes[i]}, 28'h0);
                settle(s);
                chk({8'h00, i_dev.cmd_q}, {8'h00, codes[i]});
            end
            u = (m == 0) ? 8'h01 : 8'($urandom());
            while (legal(u)) u++;
            send(nfh_pkg::K_CMD, {8'h00, u}, 28'h0);
            chk1(cmd_reject, 1'b1);
            settle(s);
            chk({8'h00, i_dev.cmd_q}, 16'h00ec);
            $display("command test done, mode %0d", m);
            for (int w = 1; w >= 0; w--) begin
                write_allow = w[0];
                c = 4'($urandom() % 12);
                a = {24'($urandom()), c} & (x16_mode ? 28'h7ffffff : 28'hfffffff);
                @(negedge clock);
                chk1(wp_n, write_allow);
                send(nfh_pkg::K_CMD, 16'h0080, 28'h0);
                send(nfh_pkg::K_ADDR, 16'h0000, a);
                repeat (10) @(negedge clock);
                for (int i = 0; i < 4; i++) chk(i_dev.ab[i], pack(a, i, x16_mode));
                chk1(ce_n, 1'b1);
                chk1(io_oe, 1'b0);
                for (int k = 0; k < 3; k++) begin
                    d = x16_mode ? 16'($urandom()) : {8'h00, 8'($urandom())};
                    send(nfh_pkg::K_WDATA, d, 28'h0);
                    if (w == 1) exp_mem[c + 4'(k)] = d;
                end
                send(nfh_pkg::K_CMD, 16'h0010, 28'h0);
                settle(s);
                chk1(s, write_allow);
                send(nfh_pkg::K_CMD, 16'h0000, 28'h0);
                send(nfh_pkg::K_ADDR, 16'h0000, a);
                send(nfh_pkg::K_CMD, 16'h0030, 28'h0);
                settle(s);
                chk1(s, 1'b1);
                send(nfh_pkg::K_RDATA, 16'h0000, 28'h0);
                send(nfh_pkg::K_RDATA, 16'h0000, 28'h0);
                repeat (4) @(negedge clock);
                chk1(req_ready, 1'b0);
                pop(rexp(c));
                pop(rexp(c + 4'h1));
                send(nfh_pkg::K_RDATA, 16'h0000, 28'h0);
                pop(rexp(c + 4'h2));
                $display("program and read test done, mode %0d, guard %0d", m, w);
            end
        end
        results();
    end
endmodule : tb
